// ---- core/caf_pkg.sv ----
// Package for the core arithmetic and port read-modify-write datapath
package caf_pkg;

    // Operation codes
    typedef enum logic [4:0] {
        CAF_OP_NONE = 5'h00,
        CAF_OP_ADD = 5'h01,
        CAF_OP_ADDC = 5'h02,
        CAF_OP_SUBB = 5'h03,
        CAF_OP_MUL = 5'h04,
        CAF_OP_DIV = 5'h05,
        CAF_OP_DA = 5'h06,
        CAF_OP_RRC = 5'h07,
        CAF_OP_RLC = 5'h08,
        CAF_OP_CJNE = 5'h09,
        CAF_OP_PANL = 5'h0a,
        CAF_OP_PORL = 5'h0b,
        CAF_OP_PXRL = 5'h0c,
        CAF_OP_PJBC = 5'h0d,
        CAF_OP_PCPL = 5'h0e,
        CAF_OP_PINC = 5'h0f,
        CAF_OP_PDEC = 5'h10,
        CAF_OP_PDJNZ = 5'h11,
        CAF_OP_PMOVC = 5'h12,
        CAF_OP_PCLR = 5'h13,
        CAF_OP_PSETB = 5'h14,
        CAF_OP_PIN_BYTE = 5'h15,
        CAF_OP_PIN_BIT = 5'h16
    } caf_op_type;

    // One instruction request
    typedef struct packed {
        caf_op_type op;
        logic [7:0] src;
        logic [2:0] bit_sel;
    } caf_req_type;

    // Arithmetic flags
    typedef struct packed {
        logic unsigned_wrap_bit;
        logic signed_wrap_bit;
        logic low_nibble_wrap_bit;
    } caf_flags_type;

    localparam logic [7:0] CAF_ACC_RESET = 8'h00;
    localparam logic [7:0] CAF_B_RESET = 8'h00;
    localparam logic [7:0] CAF_LATCH_RESET = 8'hff;
    localparam logic [7:0] CAF_DA_LOW_FIX = 8'h06;
    localparam logic [7:0] CAF_DA_HIGH_FIX = 8'h60;
    localparam logic [3:0] CAF_DA_NIBBLE_MAX = 4'h9;
    localparam logic [8:0] CAF_DA_RESULT_MAX = 9'h099;
    localparam logic [15:0] CAF_MUL_BYTE_MAX = 16'h00ff;

endpackage

// ---- core/caf_alu.sv ----
// Arithmetic flags datapath and port read-modify-write logic
// What this block does
// - Port read-modify-write takes its source from the output latch.
// - Plain port input reads the synchronised pin level.
// - Latch class: AND, OR, XOR, JBC, CPL, INC, DEC, DJNZ, bit ops.
// - Bit writes read whole latch, change one bit, write byte back.
// - Add sets carry on carry out of bit 7.
// - Add-with-carry adds carry too, flags as plain add.
// - Additions set signed wrap when exactly one of carries 6,7 occurs.
// - Additions set nibble wrap on carry out of bit 3.
// - Subtract-with-borrow subtracts source and carry; carry is borrow 7.
// - Subtraction sets signed wrap when borrow in exactly one of 6,7.
// - Subtraction sets nibble wrap on borrow from bit 3.
// - Multiply: low byte to A, high to B, carry clear, wrap if >255.
// - Divide: quotient to A, remainder to B, carry cleared.
// - Divide clears signed wrap unless divisor zero, then sets it.
// - Decimal adjust adds 06h if nibble wrap or low nibble over 9.
// - Then adds 60h if carry was set or low fix was added.
// - Decimal adjust carry set when result exceeds 99h.
// - Rotate right through carry.
// - Rotate left through carry.
// - Compare branches when source and destination differ.
// - Compare sets carry when source exceeds destination unsigned.
`timescale 1ns/10ps
`default_nettype none

module caf_alu (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire caf_pkg::caf_req_type req_i,
    input wire logic [7:0] port_pin_i,
    output logic [7:0] acc_o,
    output logic [7:0] b_o,
    output caf_pkg::caf_flags_type flags_o,
    output logic [7:0] port_latch_o,
    output logic [7:0] read_data_o,
    output logic branch_o
);
    import caf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] acc;
    logic [7:0] breg;
    caf_flags_type flags;
    logic [7:0] latch;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [7:0] read_data;
    logic branch;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic
    wire logic cy = flags.unsigned_wrap_bit;
    wire logic add_cin = (req_i.op == CAF_OP_ADDC) ? cy : 1'b0;
    wire logic [4:0] add_lo = {1'b0, acc[3:0]} + {1'b0, req_i.src[3:0]}
        + {4'h0, add_cin};
    wire logic [7:0] add_l7 = {1'b0, acc[6:0]} + {1'b0, req_i.src[6:0]}
        + {7'h00, add_cin};
    wire logic [8:0] add_sum = {1'b0, acc} + {1'b0, req_i.src}
        + {8'h00, add_cin};
    wire logic [4:0] sub_lo = {1'b0, acc[3:0]} - {1'b0, req_i.src[3:0]}
        - {4'h0, cy};
    wire logic [7:0] sub_l7 = {1'b0, acc[6:0]} - {1'b0, req_i.src[6:0]}
        - {7'h00, cy};
    wire logic [8:0] sub_dif = {1'b0, acc} - {1'b0, req_i.src}
        - {8'h00, cy};
    wire logic [15:0] product = {8'h00, acc} * {8'h00, breg};
    wire logic div_zero = (breg == 8'h00);
    wire logic [7:0] quotient = div_zero ? 8'hff : acc / breg;
    wire logic [7:0] remainder = div_zero ? acc : acc % breg;
    wire logic da_low = flags.low_nibble_wrap_bit
        || (acc[3:0] > CAF_DA_NIBBLE_MAX);
    wire logic [8:0] da_step1 = {1'b0, acc}
        + (da_low ? {1'b0, CAF_DA_LOW_FIX} : 9'h000);
    wire logic da_high = cy || da_low;
    wire logic [8:0] da_step2 = da_step1
        + (da_high ? {1'b0, CAF_DA_HIGH_FIX} : 9'h000);

    ////////////////////////////////////////////////////////////////////////
    // Port latch read-modify-write
    function automatic logic [7:0] caf_bit_mask(input logic [2:0] sel);
        caf_bit_mask = 8'h01 << sel;
    endfunction

    wire logic [7:0] mask = caf_bit_mask(req_i.bit_sel);
    wire logic latch_bit = |(latch & mask);
    wire logic pin_bit = |(pin_sync & mask);
    wire logic [7:0] latch_dec = latch - 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // Next-state selection
    logic [7:0] next_acc;
    logic [7:0] next_b;
    caf_flags_type next_flags;
    logic [7:0] next_latch;
    logic [7:0] next_read;
    logic next_branch;

    always_comb begin
        // Flags hold unless the instruction affects them
        next_acc = acc;
        next_b = breg;
        next_flags = flags;
        next_latch = latch;
        next_read = read_data;
        next_branch = 1'b0;
        unique case (req_i.op)
            CAF_OP_NONE: begin
                next_branch = 1'b0;
            end
            CAF_OP_ADD, CAF_OP_ADDC: begin
                next_acc = add_sum[7:0];
                next_flags.unsigned_wrap_bit = add_sum[8];
                next_flags.signed_wrap_bit = add_sum[8] ^ add_l7[7];
                next_flags.low_nibble_wrap_bit = add_lo[4];
            end
            CAF_OP_SUBB: begin
                next_acc = sub_dif[7:0];
                next_flags.unsigned_wrap_bit = sub_dif[8];
                next_flags.signed_wrap_bit = sub_dif[8] ^ sub_l7[7];
                next_flags.low_nibble_wrap_bit = sub_lo[4];
            end
            CAF_OP_MUL: begin
                next_acc = product[7:0];
                next_b = product[15:8];
                next_flags.unsigned_wrap_bit = 1'b0;
                next_flags.signed_wrap_bit = product > CAF_MUL_BYTE_MAX;
            end
            CAF_OP_DIV: begin
                next_acc = quotient;
                next_b = remainder;
                next_flags.unsigned_wrap_bit = 1'b0;
                next_flags.signed_wrap_bit = div_zero;
            end
            CAF_OP_DA: begin
                next_acc = da_step2[7:0];
                next_flags.unsigned_wrap_bit = da_step2 > CAF_DA_RESULT_MAX;
            end
            CAF_OP_RRC: begin
                next_acc = {cy, acc[7:1]};
                next_flags.unsigned_wrap_bit = acc[0];
            end
            CAF_OP_RLC: begin
                next_acc = {acc[6:0], cy};
                next_flags.unsigned_wrap_bit = acc[7];
            end
            CAF_OP_CJNE: begin
                next_branch = (acc != req_i.src);
                next_flags.unsigned_wrap_bit = req_i.src > acc;
            end
            CAF_OP_PANL: begin
                next_latch = latch & req_i.src;
            end
            CAF_OP_PORL: begin
                next_latch = latch | req_i.src;
            end
            CAF_OP_PXRL: begin
                next_latch = latch ^ req_i.src;
            end
            CAF_OP_PINC: begin
                next_latch = latch + 8'h01;
            end
            CAF_OP_PDEC: begin
                next_latch = latch_dec;
            end
            CAF_OP_PDJNZ: begin
                next_latch = latch_dec;
                next_branch = (latch_dec != 8'h00);
            end
            CAF_OP_PJBC: begin
                next_latch = latch & ~mask;
                next_branch = latch_bit;
            end
            CAF_OP_PCPL: begin
                next_latch = latch ^ mask;
            end
            CAF_OP_PMOVC: begin
                next_latch = cy ? (latch | mask) : (latch & ~mask);
            end
            CAF_OP_PCLR: begin
                next_latch = latch & ~mask;
            end
            CAF_OP_PSETB: begin
                next_latch = latch | mask;
            end
            CAF_OP_PIN_BYTE: begin
                next_read = pin_sync;
            end
            CAF_OP_PIN_BIT: begin
                next_read = {7'h00, pin_bit};
            end
            default: begin
                next_branch = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_i) begin
        pin_meta <= port_pin_i;
        pin_sync <= pin_meta;
        if (reset_i) begin
            acc <= CAF_ACC_RESET;
            breg <= CAF_B_RESET;
            flags <= '0;
            latch <= CAF_LATCH_RESET;
            read_data <= 8'h00;
            branch <= 1'b0;
        end else begin
            acc <= next_acc;
            breg <= next_b;
            flags <= next_flags;
            latch <= next_latch;
            read_data <= next_read;
            branch <= next_branch;
        end
    end

    assign acc_o = acc;
    assign b_o = breg;
    assign flags_o = flags;
    assign port_latch_o = latch;
    assign read_data_o = read_data;
    assign branch_o = branch;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Add carry check
    add_carry_a: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.op == CAF_OP_ADD |=> flags.unsigned_wrap_bit
        == (({1'b0, $past(acc)} + {1'b0, $past(req_i.src)}) > 9'h0ff))
        else $error("add carry wrong");
    mul_result_a: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.op == CAF_OP_MUL |=> {breg, acc}
        == {8'h00, $past(acc)} * {8'h00, $past(breg)}
        && !flags.unsigned_wrap_bit
        && flags.signed_wrap_bit == (breg != 8'h00))
        else $error("multiply wrong");
    div_zero_a: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.op == CAF_OP_DIV |=> flags.signed_wrap_bit
        == ($past(breg) == 8'h00))
        else $error("divide overflow wrong");
    rrc_rotate_a: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.op == CAF_OP_RRC |=> flags.unsigned_wrap_bit == $past(acc[0])
        && acc[7] == $past(cy))
        else $error("rotate right wrong");
    rlc_rotate_a: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.op == CAF_OP_RLC |=> flags.unsigned_wrap_bit == $past(acc[7])
        && acc[0] == $past(cy))
        else $error("rotate left wrong");
    cjne_branch_a: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.op == CAF_OP_CJNE |=> branch == ($past(acc) != $past(req_i.src)))
        else $error("compare branch wrong");
    bit_set_a: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.op == CAF_OP_PSETB |=> latch
        == ($past(latch) | (8'h01 << $past(req_i.bit_sel))))
        else $error("bit set wrong");
    flags_hold_a: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.op == CAF_OP_NONE |=> $stable(flags))
        else $error("flags changed");
    pin_read_a: assert property (@(posedge clk_i)
        disable iff (reset_i)
        req_i.op == CAF_OP_PIN_BYTE |=> read_data == $past(pin_sync))
        else $error("pin read wrong");

endmodule

`default_nettype wire

// ---- tb/caf_pin_load.sv ----
// Port pin load model: external circuitry on the port pins
`timescale 1ns/10ps
`default_nettype none

module caf_pin_load (
    input wire logic [7:0] latch_i,
    input wire logic [7:0] load_i,
    output logic [7:0] pin_o
);
    ////////////////////////////////////////////////////////////////////
    // A loaded pin reads low even while its latch bit is high
    assign pin_o = latch_i & ~load_i;
endmodule

`default_nettype wire

// ---- tb/caf_alu_tb_top.sv ----
// Self-checking bench for the arithmetic flags and port datapath
`timescale 1ns/10ps
`default_nettype none

module caf_alu_tb_top;
    import caf_pkg::*;
    logic clk_i;
    logic reset_i;
    caf_req_type req_i;
    logic [7:0] load, pin, acc_o, b_o, latch_o, rd_o, rmask;
    caf_flags_type flags_o;
    logic branch_o;
    int mismatches, samples_checked, seed;
    logic [7:0] ma, mb, ml, mr;
    logic mc, mo, mn, mj;

    caf_alu u_caf_alu (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i),
        .port_pin_i(pin), .acc_o(acc_o), .b_o(b_o), .flags_o(flags_o),
        .port_latch_o(latch_o), .read_data_o(rd_o), .branch_o(branch_o));
    caf_pin_load u_caf_pin_load (.latch_i(latch_o), .load_i(load),
        .pin_o(pin));

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Reference model of one instruction
    function automatic void predict(caf_op_type op, logic [7:0] s,
                                    logic [2:0] k);
        logic [8:0] t;
        logic [7:0] h;
        logic [4:0] n;
        logic [15:0] p;
        logic cin, lo;
        mj = 1'b0;
        cin = (op != CAF_OP_ADD) & mc;
        case (op)
            CAF_OP_ADD, CAF_OP_ADDC, CAF_OP_SUBB: begin
                if (op == CAF_OP_SUBB) begin
                    t = {1'b0, ma} - {1'b0, s} - 9'(cin);
                    h = {1'b0, ma[6:0]} - {1'b0, s[6:0]} - 8'(cin);
                    n = {1'b0, ma[3:0]} - {1'b0, s[3:0]} - 5'(cin);
                end else begin
                    t = {1'b0, ma} + {1'b0, s} + 9'(cin);
                    h = {1'b0, ma[6:0]} + {1'b0, s[6:0]} + 8'(cin);
                    n = {1'b0, ma[3:0]} + {1'b0, s[3:0]} + 5'(cin);
                end
                ma = t[7:0];
                mc = t[8];
                mo = t[8] ^ h[7];
                mn = n[4];
            end
            CAF_OP_MUL: begin
                p = 16'(ma) * 16'(mb);
                {mb, ma} = p;
                mc = 1'b0;
                mo = p > 16'h00ff;
            end
            CAF_OP_DIV: begin
                mc = 1'b0;
                mo = (mb == 8'h00);
                if (mo) begin
                    mb = ma;
                    ma = 8'hff;
                end else begin
                    t = {1'b0, ma / mb};
                    mb = ma % mb;
                    ma = t[7:0];
                end
            end
            CAF_OP_DA: begin
                lo = mn || (ma[3:0] > 4'h9);
                t = {1'b0, ma} + (lo ? 9'h006 : 9'h000);
                if (mc || lo) begin
                    t = t + 9'h060;
                end
                mc = t > 9'h099;
                ma = t[7:0];
            end
            CAF_OP_RRC: {ma, mc} = {mc, ma};
            CAF_OP_RLC: {mc, ma} = {ma, mc};
            CAF_OP_CJNE: begin
                mj = s != ma;
                mc = s > ma;
            end
            CAF_OP_PANL: ml = ml & s;
            CAF_OP_PORL: ml = ml | s;
            CAF_OP_PXRL: ml = ml ^ s;
            CAF_OP_PJBC: begin
                mj = ml[k];
                ml[k] = 1'b0;
            end
            CAF_OP_PCPL: ml[k] = ~ml[k];
            CAF_OP_PINC: ml = ml + 8'h01;
            CAF_OP_PDEC: ml = ml - 8'h01;
            CAF_OP_PDJNZ: begin
                ml = ml - 8'h01;
                mj = ml != 8'h00;
            end
            CAF_OP_PMOVC: ml[k] = mc;
            CAF_OP_PCLR: ml[k] = 1'b0;
            CAF_OP_PSETB: ml[k] = 1'b1;
            CAF_OP_PIN_BYTE: mr = pin;
            CAF_OP_PIN_BIT: mr = {7'h00, pin[k]};
            default: ;
        endcase
    endfunction

    // Drive one request just after an edge, compare one cycle later
    task automatic step(caf_op_type op, logic [7:0] s, logic [2:0] k);
        req_i = '{op, s, k};
        predict(op, s, k);
        @(posedge clk_i);
        #1;
        check("acc", acc_o, ma);
        check("b", b_o, mb);
        check("flags", {5'h00, flags_o}, {5'h00, mc, mo, mn});
        check("latch", latch_o, ml);
        check("branch", {7'h00, branch_o}, {7'h00, mj});
        check("read", rd_o & rmask, mr & rmask);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        final_report();
    end

    initial begin
        seed = 32'hef40;
        mismatches = 0;
        samples_checked = 0;
        reset_i = 1'b1;
        req_i = '{CAF_OP_NONE, 8'h00, 3'h0};
        load = 8'h00;
        rmask = 8'hff;
        {ma, mb} = {CAF_ACC_RESET, CAF_B_RESET};
        {ml, mr} = {CAF_LATCH_RESET, 8'h00};
        {mc, mo, mn, mj} = 4'h0;
        repeat (12) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        step(CAF_OP_NONE, 8'h00, 3'h0);
        step(caf_op_type'(5'h1f), 8'h00, 3'h0);
        // Carry, signed and nibble wrap corners
        step(CAF_OP_ADD, 8'h7f, 3'h0);
        step(CAF_OP_ADD, 8'h01, 3'h0);
        step(CAF_OP_ADD, 8'h80, 3'h0);
        step(CAF_OP_ADDC, 8'hff, 3'h0);
        step(CAF_OP_SUBB, 8'h01, 3'h0);
        step(CAF_OP_SUBB, 8'h7f, 3'h0);
        step(CAF_OP_DIV, 8'h00, 3'h0);
        step(CAF_OP_MUL, 8'h00, 3'h0);
        step(CAF_OP_CJNE, ma, 3'h0);
        // Port decrement to zero and jump-and-clear
        step(CAF_OP_PANL, 8'h01, 3'h0);
        step(CAF_OP_PDJNZ, 8'h00, 3'h0);
        step(CAF_OP_PDJNZ, 8'h00, 3'h0);
        step(CAF_OP_PJBC, 8'h00, 3'h7);
        step(CAF_OP_PJBC, 8'h00, 3'h7);
        for (int i = 0; i < 1500; i++) begin
            step(caf_op_type'(5'(1 + ($unsigned($random(seed)) % 20))),
                 8'($random(seed)), 3'($random(seed)));
        end
        // Loaded pins: inputs see the pin, port updates see the latch
        step(CAF_OP_PORL, 8'hff, 3'h0);
        load = 8'h0f;
        repeat (3) step(CAF_OP_NONE, 8'h00, 3'h0);
        step(CAF_OP_PIN_BYTE, 8'h00, 3'h0);
        rmask = 8'h01;
        step(CAF_OP_PIN_BIT, 8'h00, 3'h2);
        step(CAF_OP_PIN_BIT, 8'h00, 3'h7);
        step(CAF_OP_PXRL, 8'h00, 3'h0);
        step(CAF_OP_PSETB, 8'h00, 3'h0);
        step(CAF_OP_PCLR, 8'h00, 3'h5);
        step(CAF_OP_PMOVC, 8'h00, 3'h1);
        step(CAF_OP_PINC, 8'h00, 3'h0);
        final_report();
    end
endmodule

`default_nettype wire
